// File: dlsr_chan.sv
`timescale 1ns/10ps
module dlsr_chan
  import dlsr_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire dlsr_fr_in_s   fr_i,
  input  wire logic          rd_code_i,
  input  wire logic          rd_rhs_i,
  input  wire logic          rd_txs_i,
  output dlsr_chan_st_s      st_o
);

  logic       code_sticky_ff, nxt_code_sticky;
  logic [5:0] code_word_ff,   nxt_code_word;
  logic       live_ff,        nxt_live;
  logic [2:0] ones_ff,        nxt_ones;
  logic       abt_ff,  nxt_abt;
  logic       crc_ff,  nxt_crc;
  logic       ovr_ff,  nxt_ovr;
  logic       vm_ff,   nxt_vm;
  logic       udr_ff,  nxt_udr;
  logic       abt_ev;

  // ------------------------------------------------------------------
  // next state; every sticky flag lets a same-cycle event beat the clear
  // ------------------------------------------------------------------
  always_comb begin
    nxt_ones = ones_ff;
    abt_ev   = 1'b0;
    if (fr_i.rx_bit_en) begin
      if (fr_i.rx_bit) begin
        if (ones_ff != DLSR_ABORT_ONES) begin
          nxt_ones = ones_ff + 3'h1;
        end
        abt_ev = (ones_ff == DLSR_ABORT_ONES - 3'h1);  // [R12]
      end else begin
        nxt_ones = 3'h0;
      end
    end
    nxt_live        = fr_i.code_live;
    nxt_code_sticky = (code_sticky_ff & ~rd_code_i) | fr_i.code_live;  // [R2]
    nxt_code_word   = fr_i.code_valid ? fr_i.code_word : code_word_ff;  // [R5]
    nxt_abt = (abt_ff & ~rd_rhs_i) | abt_ev;                            // [R1]
    nxt_crc = (crc_ff & ~rd_rhs_i) | fr_i.crc_err;                      // [R1]
    nxt_ovr = (ovr_ff & ~rd_rhs_i) | fr_i.overrun;                      // [R1]
    nxt_vm  = (vm_ff  & ~rd_rhs_i) | fr_i.valid_msg;                    // [R1]
    nxt_udr = (udr_ff & ~rd_txs_i) | fr_i.tx_underrun;                  // [R11]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_sticky_ff <= 1'b0;
      code_word_ff   <= DLSR_CODE_RST;  // [R6]
      live_ff        <= 1'b0;
      ones_ff        <= 3'h0;
      abt_ff         <= 1'b0;
      crc_ff         <= 1'b0;
      ovr_ff         <= 1'b0;
      vm_ff          <= 1'b0;
      udr_ff         <= 1'b0;
    end else begin
      code_sticky_ff <= nxt_code_sticky;
      code_word_ff   <= nxt_code_word;
      live_ff        <= nxt_live;
      ones_ff        <= nxt_ones;
      abt_ff         <= nxt_abt;
      crc_ff         <= nxt_crc;
      ovr_ff         <= nxt_ovr;
      vm_ff          <= nxt_vm;
      udr_ff         <= nxt_udr;
    end
  end

  // ------------------------------------------------------------------
  // register images; live bits come straight from the framer
  // ------------------------------------------------------------------
  always_comb begin
    st_o = '0;
    st_o.code[DLSR_CODE_STICKY] = code_sticky_ff;
    st_o.code[DLSR_CODE_LIVE]   = fr_i.code_live;      // [R3]
    st_o.code[5:0]              = code_word_ff;        // [R4]
    st_o.rhs[DLSR_RHS_ABT]      = abt_ff;
    st_o.rhs[DLSR_RHS_CRC]      = crc_ff;
    st_o.rhs[DLSR_RHS_OVR]      = ovr_ff;
    st_o.rhs[DLSR_RHS_VM]       = vm_ff;
    st_o.rhs[DLSR_RHS_EMPTY]    = fr_i.rx_fifo_empty;
    st_o.txs[DLSR_TXS_EMPTY]    = fr_i.tx_empty;       // [R9]
    st_o.txs[DLSR_TXS_FULL]     = fr_i.tx_full;        // [R8]
    st_o.txs[DLSR_TXS_UDR]      = udr_ff;
    st_o.ev[DLSR_EV_CODE]       = fr_i.code_live & ~live_ff;
    st_o.ev[DLSR_EV_ABT]        = abt_ev;
    st_o.ev[DLSR_EV_CRC]        = fr_i.crc_err;
    st_o.ev[DLSR_EV_OVR]        = fr_i.overrun;
    st_o.ev[DLSR_EV_VM]         = fr_i.valid_msg;
    st_o.ev[DLSR_EV_UDR]        = fr_i.tx_underrun;
  end

endmodule : dlsr_chan

// File: dlsr_host.sv
`timescale 1ns/10ps
module dlsr_host
  import dlsr_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               ack_i,
  input  wire logic [31:0]        dat_i,
  output logic                    cyc_o,
  output logic                    stb_o,
  output logic                    we_o,
  output logic      [DLSR_AW-1:0] adr_o,
  output logic      [31:0]        dat_o,
  output logic      [3:0]         sel_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} = '0;
  end
  // ------------------------------------------------------------------
  // single classic cycle; ack is sampled at the rising edge, before the
  // slave's flops move in that time step, and the request drops there
  // ------------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    ok = 1'b0;
    rd = '0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= wd;
    sel_o <= 4'hf;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        rd = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
  endtask : xfer
endmodule : dlsr_host

// File: dlsr_irq.sv
`timescale 1ns/10ps
module dlsr_irq
  import dlsr_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [DLSR_IRQW-1:0] ev_i,
  input  wire logic                 wr_st_i,
  input  wire logic                 wr_mask_i,
  input  wire logic [DLSR_IRQW-1:0] wdat_i,
  input  wire logic [1:0]           be_i,
  output logic      [DLSR_IRQW-1:0] st_o,
  output logic      [DLSR_IRQW-1:0] mask_o,
  output logic                      irq_o
);

  logic [DLSR_IRQW-1:0] st_ff, nxt_st;
  logic [DLSR_IRQW-1:0] mask_ff, nxt_mask;
  logic [DLSR_IRQW-1:0] lane;

  // ------------------------------------------------------------------
  // write-one-to-clear status, byte-lane gated; set beats clear
  // ------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DLSR_IRQW; i++) begin
      lane[i] = be_i[i / 8];
    end
    nxt_st   = (st_ff & ~(wdat_i & lane & {DLSR_IRQW{wr_st_i}})) | ev_i;
    nxt_mask = wr_mask_i ? ((mask_ff & ~lane) | (wdat_i & lane)) : mask_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff   <= '0;
      mask_ff <= DLSR_MASK_RST;
    end else begin
      st_ff   <= nxt_st;
      mask_ff <= nxt_mask;
    end
  end

  assign st_o   = st_ff;
  assign mask_o = mask_ff;
  assign irq_o  = |(st_ff & mask_ff);

endmodule : dlsr_irq

// File: dlsr_pkg.sv
package dlsr_pkg;

  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int DLSR_NFR  = 2;
  localparam int DLSR_NEV  = 6;
  localparam int DLSR_IRQW = DLSR_NFR * DLSR_NEV;
  localparam int DLSR_AW   = 10;

  // ------------------------------------------------------------------
  // register indexes (byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam logic [7:0] DLSR_IDX_RHS_A   = 8'h03;
  localparam logic [7:0] DLSR_IDX_CODE_A  = 8'h04;
  localparam logic [7:0] DLSR_IDX_RXD_A   = 8'h05;
  localparam logic [7:0] DLSR_IDX_TXS_A   = 8'h06;
  localparam logic [7:0] DLSR_IDX_RHS_B   = 8'ha3;
  localparam logic [7:0] DLSR_IDX_CODE_B  = 8'ha4;
  localparam logic [7:0] DLSR_IDX_RXD_B   = 8'ha5;
  localparam logic [7:0] DLSR_IDX_TXS_B   = 8'ha6;
  localparam logic [7:0] DLSR_IDX_IRQ_ST  = 8'h10;
  localparam logic [7:0] DLSR_IDX_IRQ_MSK = 8'h11;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int DLSR_CODE_STICKY = 7;
  localparam int DLSR_CODE_LIVE   = 6;
  localparam int DLSR_RHS_ABT     = 7;
  localparam int DLSR_RHS_CRC     = 6;
  localparam int DLSR_RHS_OVR     = 5;
  localparam int DLSR_RHS_VM      = 4;
  localparam int DLSR_RHS_EMPTY   = 3;
  localparam int DLSR_TXS_EMPTY   = 2;
  localparam int DLSR_TXS_FULL    = 1;
  localparam int DLSR_TXS_UDR     = 0;

  // interrupt event positions within one framer's group
  localparam int DLSR_EV_CODE = 0;
  localparam int DLSR_EV_ABT  = 1;
  localparam int DLSR_EV_CRC  = 2;
  localparam int DLSR_EV_OVR  = 3;
  localparam int DLSR_EV_VM   = 4;
  localparam int DLSR_EV_UDR  = 5;

  // ------------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------------
  localparam logic [5:0]           DLSR_CODE_RST  = 6'h3f;
  localparam logic [2:0]           DLSR_ABORT_ONES = 3'h7;
  localparam logic [DLSR_IRQW-1:0] DLSR_MASK_RST  = 12'h000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    DLSR_WB_IDLE = 2'b01,
    DLSR_WB_ACK  = 2'b10
  } dlsr_wb_e;

  typedef struct packed {
    logic       code_live;
    logic       code_valid;
    logic [5:0] code_word;
    logic       rx_bit;
    logic       rx_bit_en;
    logic       crc_err;
    logic       overrun;
    logic       valid_msg;
    logic       rx_fifo_empty;
    logic [7:0] rx_fifo_data;
    logic       tx_full;
    logic       tx_empty;
    logic       tx_underrun;
  } dlsr_fr_in_s;

  typedef struct packed {
    logic [7:0]          code;
    logic [7:0]          rhs;
    logic [7:0]          txs;
    logic [DLSR_NEV-1:0] ev;
  } dlsr_chan_st_s;

endpackage : dlsr_pkg

// File: dlsr_top.sv
// Function
// [R1] rx abort, crc error, overrun, valid-message flags latch; cleared by reading them.
// [R2] code bit 7 is sticky copy of live detect, cleared by reading.
// [R3] code bit 6 follows the live code detector in real time.
// [R4] code word in bits 5..0, bit 0 first received, bit 5 last.
// [R5] code bits hold the last verified code until a new one verifies.
// [R6] reset loads all six code bits with ones.
// [R7] tx status bits 7..3 unassigned; read as zero here, host ignores.
// [R8] tx status bit 1 shows tx fifo full, not latched.
// [R9] tx status bit 2 shows tx fifo empty, not latched.
// [R10] reading rx fifo data returns oldest byte, msb in bit 7, then advances.
// [R11] tx underrun bit 0 latches; cleared by reading tx status.
// [R12] abort flag sets on seven or more consecutive received ones.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
module dlsr_top
  import dlsr_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        cyc_i,
  input  wire logic                        stb_i,
  input  wire logic                        we_i,
  input  wire logic [DLSR_AW-1:0]          adr_i,
  input  wire logic [31:0]                 dat_i,
  input  wire logic [3:0]                  sel_i,
  output logic      [31:0]                 dat_o,
  output logic                             ack_o,
  input  wire dlsr_fr_in_s [DLSR_NFR-1:0]  fr_i,
  output logic      [DLSR_NFR-1:0]         rx_fifo_pop_o,
  output logic                             irq_o
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  dlsr_wb_e                 wb_state_ff, nxt_wb_state;
  logic [31:0]              dat_ff, nxt_dat;
  logic                     take;
  logic                     rd_take;
  logic                     wr_take;
  logic [7:0]               idx;
  logic [7:0]               rdata;
  logic                     hit;
  logic [DLSR_NFR-1:0]      rd_code;
  logic [DLSR_NFR-1:0]      rd_rhs;
  logic [DLSR_NFR-1:0]      rd_txs;
  logic [DLSR_NFR-1:0]      rd_rxd;
  logic                     sel_irq_st;
  logic                     sel_irq_mask;
  logic                     wr_irq_st;
  logic                     wr_irq_mask;
  dlsr_chan_st_s            chan_st [DLSR_NFR];
  logic [DLSR_IRQW-1:0]     ev_all;
  logic [DLSR_IRQW-1:0]     irq_st;
  logic [DLSR_IRQW-1:0]     irq_mask;

  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  // one request is taken per idle cycle; ack follows one cycle later and
  // drops the cycle after, so a strobe still held in the ack cycle is not taken twice
  assign take    = cyc_i & stb_i & (wb_state_ff == DLSR_WB_IDLE);
  assign rd_take = take & ~we_i;
  assign wr_take = take &  we_i;
  assign idx     = adr_i[DLSR_AW-1:2];

  always_comb begin
    nxt_wb_state = wb_state_ff;
    case (wb_state_ff)
      DLSR_WB_IDLE: begin
        if (take) begin
          nxt_wb_state = DLSR_WB_ACK;
        end
      end
      DLSR_WB_ACK: begin
        nxt_wb_state = DLSR_WB_IDLE;
      end
      default: begin
        nxt_wb_state = DLSR_WB_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // unmapped indexes still ack and read zero, so a stray access never hangs
  always_comb begin
    rd_code      = '0;
    rd_rhs       = '0;
    rd_txs       = '0;
    rd_rxd       = '0;
    sel_irq_st   = 1'b0;
    sel_irq_mask = 1'b0;
    rdata        = 8'h00;
    hit          = 1'b1;
    if (idx == DLSR_IDX_RHS_A) begin
      rd_rhs[0] = 1'b1;
      rdata     = chan_st[0].rhs;
    end else if (idx == DLSR_IDX_CODE_A) begin
      rd_code[0] = 1'b1;
      rdata      = chan_st[0].code;
    end else if (idx == DLSR_IDX_RXD_A) begin
      rd_rxd[0] = 1'b1;
      rdata     = fr_i[0].rx_fifo_data;  // [R10]
    end else if (idx == DLSR_IDX_TXS_A) begin
      rd_txs[0] = 1'b1;
      rdata     = chan_st[0].txs;        // [R7]
    end else if (idx == DLSR_IDX_RHS_B) begin
      rd_rhs[1] = 1'b1;
      rdata     = chan_st[1].rhs;
    end else if (idx == DLSR_IDX_CODE_B) begin
      rd_code[1] = 1'b1;
      rdata      = chan_st[1].code;
    end else if (idx == DLSR_IDX_RXD_B) begin
      rd_rxd[1] = 1'b1;
      rdata     = fr_i[1].rx_fifo_data;  // [R10]
    end else if (idx == DLSR_IDX_TXS_B) begin
      rd_txs[1] = 1'b1;
      rdata     = chan_st[1].txs;        // [R7]
    end else if (idx == DLSR_IDX_IRQ_ST) begin
      sel_irq_st = 1'b1;
    end else if (idx == DLSR_IDX_IRQ_MSK) begin
      sel_irq_mask = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read data capture
  // ------------------------------------------------------------------
  // the image is caught at the same edge that clears the read-sensitive
  // flags, so software sees the values that the clear removed
  always_comb begin
    nxt_dat = dat_ff;
    if (rd_take) begin
      if (sel_irq_st) begin
        nxt_dat = {{(32 - DLSR_IRQW){1'b0}}, irq_st};
      end else if (sel_irq_mask) begin
        nxt_dat = {{(32 - DLSR_IRQW){1'b0}}, irq_mask};
      end else if (hit) begin
        nxt_dat = {24'h000000, rdata};
      end else begin
        nxt_dat = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_state_ff <= DLSR_WB_IDLE;
      dat_ff      <= 32'h00000000;
    end else begin
      wb_state_ff <= nxt_wb_state;
      dat_ff      <= nxt_dat;
    end
  end

  assign ack_o = (wb_state_ff == DLSR_WB_ACK);
  assign dat_o = dat_ff;

  // ------------------------------------------------------------------
  // read side effects
  // ------------------------------------------------------------------
  // popping an empty fifo is suppressed rather than left to the fifo
  always_comb begin
    for (int f = 0; f < DLSR_NFR; f++) begin
      rx_fifo_pop_o[f] = rd_take & rd_rxd[f] & ~fr_i[f].rx_fifo_empty;  // [R10]
    end
  end

  // ------------------------------------------------------------------
  // framer channels
  // ------------------------------------------------------------------
  for (genvar g = 0; g < DLSR_NFR; g++) begin : g_chan
    dlsr_chan u_chan (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .fr_i      (fr_i[g]),
      .rd_code_i (rd_take & rd_code[g]),  // [R2]
      .rd_rhs_i  (rd_take & rd_rhs[g]),   // [R1]
      .rd_txs_i  (rd_take & rd_txs[g]),   // [R11]
      .st_o      (chan_st[g])
    );
    assign ev_all[g*DLSR_NEV +: DLSR_NEV] = chan_st[g].ev;
  end

  // ------------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------------
  assign wr_irq_st   = wr_take & sel_irq_st;
  assign wr_irq_mask = wr_take & sel_irq_mask;

  dlsr_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ev_i      (ev_all),
    .wr_st_i   (wr_irq_st),
    .wr_mask_i (wr_irq_mask),
    .wdat_i    (dat_i[DLSR_IRQW-1:0]),
    .be_i      (sel_i[1:0]),
    .st_o      (irq_st),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

endmodule : dlsr_top

// File: dlsr_top_asserts.sv
`timescale 1ns/10ps
module dlsr_top_asserts
  import dlsr_pkg::*;
(
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [DLSR_AW-1:0]         adr_i,
  input  wire logic [31:0]                dat_o,
  input  wire logic                       ack_o,
  input  wire dlsr_fr_in_s [DLSR_NFR-1:0] fr_i,
  input  wire logic [DLSR_NFR-1:0]        rx_fifo_pop_o
);
  // ------------------------------------------------------------------
  // tracking of taken reads, framer a only
  // ------------------------------------------------------------------
  logic       take;
  logic [7:0] idx;
  logic       rd_code_ff, rd_txs_ff, rd_rxd_ff, nxt_code_rd, nxt_txs_rd, nxt_rxd_rd;
  logic [5:0] code_ff, nxt_code;
  assign take = cyc_i && stb_i && !ack_o;
  assign idx  = adr_i[9:2];
  always_comb begin
    nxt_code_rd = take && !we_i && idx == DLSR_IDX_CODE_A;
    nxt_txs_rd  = take && !we_i && idx == DLSR_IDX_TXS_A;
    nxt_rxd_rd  = take && !we_i && idx == DLSR_IDX_RXD_A;
    nxt_code    = fr_i[0].code_valid ? fr_i[0].code_word : code_ff;
  end
  always_ff @(posedge clk_i) begin
    rd_code_ff <= rst_i ? 1'b0 : nxt_code_rd;
    rd_txs_ff  <= rst_i ? 1'b0 : nxt_txs_rd;
    rd_rxd_ff  <= rst_i ? 1'b0 : nxt_rxd_rd;
    code_ff    <= rst_i ? DLSR_CODE_RST : nxt_code;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_answer;
    ##1 ack_o ##1 !ack_o;
  endsequence
  bus_answer_a: assert property (s_take |-> s_answer) else $error("ack missing or too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  code_live_a: assert property (ack_o && rd_code_ff |-> dat_o[DLSR_CODE_LIVE] == $past(fr_i[0].code_live))
    else $error("live detect bit wrong");
  code_word_a: assert property (ack_o && rd_code_ff |-> dat_o[5:0] == $past(code_ff))
    else $error("code word wrong");
  code_sticky_a: assert property (ack_o && rd_code_ff && $past(fr_i[0].code_live, 2) |-> dat_o[7])
    else $error("sticky detect lost");
  tx_flags_a: assert property (ack_o && rd_txs_ff |-> dat_o[2:1] == $past({fr_i[0].tx_empty, fr_i[0].tx_full}))
    else $error("tx level flags wrong");
  rx_data_a: assert property (ack_o && rd_rxd_ff |-> dat_o[7:0] == $past(fr_i[0].rx_fifo_data))
    else $error("rx data not head byte");
  fifo_pop_a: assert property (1'b1 |-> rx_fifo_pop_o[0] == (nxt_rxd_rd && !fr_i[0].rx_fifo_empty))
    else $error("pop mismatch");
  upper_zero_a: assert property (ack_o |-> dat_o[31:12] == 20'h00000) else $error("upper data bits set");
endmodule : dlsr_top_asserts

// File: tb_dlsr_top.sv
`timescale 1ns/10ps
module tb_dlsr_top
  import dlsr_pkg::*;
;
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic                       cyc, stb, we, ack, irq;
  logic [DLSR_AW-1:0]         adr;
  logic [31:0]                wdat, rdat;
  logic [3:0]                 sel;
  logic [DLSR_NFR-1:0]        pop;
  dlsr_fr_in_s [DLSR_NFR-1:0] fr;
  int                         err_total = 0, tests_run = 0, pops = 0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) pops <= pops + int'(pop[0]);
  dlsr_top u_dlsr_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack), .fr_i(fr), .rx_fifo_pop_o(pop), .irq_o(irq));
  dlsr_host u_dlsr_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    bit ok;
    u_dlsr_host.xfer(w, idx, wd, rd, ok);
    if (!ok) begin
      err_total++;
      $display("Error bus ack expected 1 seen 0");
      summarize();
    end
  endtask : acc
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    acc(1'b0, idx, 32'h0, d);
    chk(nm, d & m, exp);
  endtask : rdc
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    acc(1'b1, idx, wd, d);
  endtask : wr
  task automatic bits(input int n, input logic b);
    repeat (n) begin
      @(posedge clk_i);
      fr[0].rx_bit    <= b;
      fr[0].rx_bit_en <= 1'b1;
    end
    @(posedge clk_i);
    fr[0].rx_bit_en <= 1'b0;
  endtask : bits
  initial begin
    logic [7:0] cx, tx;
    logic [7:0] q [4] = '{8'h81, 8'h5a, 8'hc3, 8'h3c};
    int         p0;
    fr = '0;
    fr[0].tx_empty = 1'b1;
    fr[1].tx_empty = 1'b1;
    fr[0].rx_fifo_empty = 1'b1;
    fr[1].rx_fifo_empty = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      cx = f ? DLSR_IDX_CODE_B : DLSR_IDX_CODE_A;
      tx = f ? DLSR_IDX_TXS_B : DLSR_IDX_TXS_A;
      rdc("code reset", cx, 32'hff, 32'h3f);
      rdc("tx empty", tx, 32'h7, 32'h4);
      rdc("rx status idle", f ? DLSR_IDX_RHS_B : DLSR_IDX_RHS_A, 32'hff, 32'h08);
      rdc("rx data idle", f ? DLSR_IDX_RXD_B : DLSR_IDX_RXD_A, 32'hff, 32'h00);
      fr[f].tx_full  <= 1'b1;
      fr[f].tx_empty <= 1'b0;
      @(posedge clk_i) fr[f].tx_underrun <= 1'b1;
      @(posedge clk_i) fr[f].tx_underrun <= 1'b0;
      rdc("tx full underrun", tx, 32'h7, 32'h3);
      rdc("tx underrun clear", tx, 32'h7, 32'h2);
    end
    $display("test reset and tx status done");
    @(posedge clk_i) {fr[0].code_live, fr[0].code_valid, fr[0].code_word} <= {2'b11, 6'h25};
    @(posedge clk_i) {fr[0].code_valid, fr[0].code_word} <= {1'b0, 6'h0a};
    rdc("code live", DLSR_IDX_CODE_A, 32'hff, 32'he5);
    @(posedge clk_i) fr[0].code_live <= 1'b0;
    repeat (2) @(posedge clk_i);
    rdc("code sticky", DLSR_IDX_CODE_A, 32'hff, 32'ha5);
    rdc("code sticky clear", DLSR_IDX_CODE_A, 32'hff, 32'h25);
    rdc("code other framer", DLSR_IDX_CODE_B, 32'hff, 32'h3f);
    $display("test code detect done");
    bits(6, 1'b1);
    bits(1, 1'b0);
    @(posedge clk_i) fr[0].crc_err <= 1'b1;
    @(posedge clk_i) fr[0].crc_err <= 1'b0;
    rdc("rx six ones", DLSR_IDX_RHS_A, 32'hff, 32'h48);
    bits(7, 1'b1);
    @(posedge clk_i) {fr[0].overrun, fr[0].valid_msg} <= 2'b11;
    @(posedge clk_i) {fr[0].overrun, fr[0].valid_msg} <= 2'b00;
    rdc("rx flags", DLSR_IDX_RHS_A, 32'hff, 32'hb8);
    rdc("rx flags clear", DLSR_IDX_RHS_A, 32'hff, 32'h08);
    p0 = pops;
    fr[0].rx_fifo_empty <= 1'b0;
    fr[0].rx_fifo_data  <= q[0];
    for (int i = 0; i < 3; i++) begin
      rdc("rx data", DLSR_IDX_RXD_A, 32'hff, {24'h0, q[i]});
      fr[0].rx_fifo_data  <= q[i+1];
      fr[0].rx_fifo_empty <= (i == 2);
    end
    rdc("rx empty read", DLSR_IDX_RXD_A, 32'hff, {24'h0, q[3]});
    @(posedge clk_i);
    chk("pop count", 32'(pops - p0), 32'h3);
    $display("test rx path done");
    wr(DLSR_IDX_IRQ_ST, 32'hfff);
    wr(DLSR_IDX_IRQ_MSK, 32'h004);
    chk("irq idle", {31'h0, irq}, 32'h0);
    @(posedge clk_i) fr[0].crc_err <= 1'b1;
    @(posedge clk_i) fr[0].crc_err <= 1'b0;
    @(posedge clk_i);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rdc("irq status", DLSR_IDX_IRQ_ST, 32'hfff, 32'h004);
    wr(DLSR_IDX_IRQ_ST, 32'h004);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(DLSR_IDX_IRQ_MSK, 32'h000);
    @(posedge clk_i) fr[0].crc_err <= 1'b1;
    @(posedge clk_i) fr[0].crc_err <= 1'b0;
    @(posedge clk_i);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc("unmapped", 8'h3f, 32'hffffffff, 32'h0);
    $display("test irq and unmapped done");
    summarize();
  end
endmodule : tb_dlsr_top

bind dlsr_top dlsr_top_asserts u_dlsr_top_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .fr_i(fr_i), .rx_fifo_pop_o(rx_fifo_pop_o));
